// *** logic/cca_capcom16.sv ***
// Purpose: Sixteen-channel capture/compare array with two time bases.
// Assumes: All inputs synchronous to pclk; APB slave with no wait.
// Notes:   Register map lives in cca_consts.svh.
`timescale 1ns/1ps
`include "cca_consts.svh"
module cca_capcom16 #(
  parameter int TW = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [15:0]       ch_in,
  output cca_pkg::cca_pins_s     ch_pins,
  input  wire logic              ext_ovf_pulse,
  input  wire logic              ext_count_in,
  output logic                   irq
);
  import cca_pkg::*;

  localparam int N = `CCA_NCH;
  localparam logic [TW-1:0] TOP = '1;

  if (TW < 8 || TW > 32) begin : g_chk
    $error("TW must lie between 8 and 32");
  end

  cca_tctl_s        tctl [2];
  logic [TW-1:0]    cnt  [2];
  logic [TW-1:0]    rel  [2];
  cca_chcfg_s       cfg  [N];
  logic [TW-1:0]    val  [N];
  logic             stagger;
  logic [7:0]       presc;
  logic [2:0]       phase;
  logic             ext_cnt_q;
  logic [N-1:0]     pin_q;
  logic [1:0]       tick;
  logic [1:0]       ovf;
  logic [1:0]       upd;
  logic [N-1:0]     match;
  logic [N-1:0]     cap;
  logic [N-1:0]     ev;
  logic [N-1:0]     dhit;
  logic [N-1:0]     out;
  logic [N-1:0]     fired;
  logic [N-1:0]     done;
  logic [N-1:0]     stat;
  logic [N-1:0]     en;
  logic             wr;
  logic [6:0]       code;
  logic [31:0]      rd_val;

  function automatic logic [6:0] dec(input logic [11:0] a);
    logic [6:0] c;
    c = `CCA_C_NONE;
    if (a == `CCA_TA_CTRL) c = `CCA_C_TCTL;
    else if (a == `CCA_TA_CNT) c = `CCA_C_TCNT;
    else if (a == `CCA_TA_REL) c = `CCA_C_TREL;
    else if (a == `CCA_TB_CTRL) c = `CCA_C_TCTL + 7'h03;
    else if (a == `CCA_TB_CNT) c = `CCA_C_TCNT + 7'h03;
    else if (a == `CCA_TB_REL) c = `CCA_C_TREL + 7'h03;
    else if (a == `CCA_GLOBAL) c = `CCA_C_GLOB;
    else if (a == `CCA_IRQ_STAT) c = `CCA_C_STAT;
    else if (a == `CCA_IRQ_CLR) c = `CCA_C_CLR;
    else if (a == `CCA_IRQ_EN) c = `CCA_C_EN;
    else if (a == `CCA_PIN_STATE) c = `CCA_C_PINS;
    else if (a[11:8] == `CCA_CH_MODE_HI && a[7:6] == 2'h0 &&
             a[1:0] == 2'h0) c = {`CCA_C_MODE, a[5:2]};
    else if (a[11:8] == `CCA_CH_VAL_HI && a[7:6] == 2'h0 &&
             a[1:0] == 2'h0) c = {`CCA_C_VAL, a[5:2]};
    return c;
  endfunction : dec

  // Divide by two to the power ps; ps of zero ticks every cycle.
  function automatic logic pre_tick(input logic [7:0] p,
                                    input logic [2:0] ps);
    logic [7:0] m;
    m = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (k < int'(ps)) m[k] = 1'b1;
    end
    return (p & m) == m;
  endfunction : pre_tick

  function automatic logic [6:0] tcode(input logic [6:0] b,
                                       input int t);
    return b + (t != 0 ? 7'h03 : 7'h00);
  endfunction : tcode

  assign pready  = 1'b1;
  assign code    = dec(paddr);
  assign wr      = psel & penable & pwrite;
  assign pslverr = psel & penable & (code == `CCA_C_NONE);
  assign irq     = |(stat & en);

  always_comb begin
    ch_pins.out = out;
    for (int i = 0; i < N; i++) begin
      ch_pins.oe_n[i] = !(cfg[i].mode == `CCA_M_CMP1 ||
                          cfg[i].mode == `CCA_M_CMP3 ||
                          (cfg[i].mode == `CCA_M_CMP0 &&
                           cfg[i].dbl)); // [R7]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc     <= 8'h00;
      phase     <= 3'h0;
      ext_cnt_q <= 1'b0;
      pin_q     <= 16'h0000;
      upd       <= 2'h0;
    end else begin
      presc     <= presc + 8'h01;
      phase     <= phase + 3'h1;
      ext_cnt_q <= ext_count_in;
      pin_q     <= ch_in;
      upd       <= tick;
    end
  end

  always_comb begin
    logic raw;
    raw = 1'b0;
    for (int t = 0; t < 2; t++) begin
      case (tctl[t].src)
        `CCA_SRC_PRE: raw = pre_tick(presc, tctl[t].ps); // [R4]
        `CCA_SRC_OVF: raw = ext_ovf_pulse; // [R4]
        default:      raw = ext_count_in & ~ext_cnt_q; // [R5]
      endcase
      // Staggered mode lets a time base move once in eight cycles.
      tick[t] = tctl[t].run & raw &
                (!stagger || phase == `CCA_STAGGER); // [R1] [R2]
      ovf[t]  = tick[t] && cnt[t] == TOP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < 2; t++) begin
        tctl[t] <= '0;
        cnt[t]  <= '0;
        rel[t]  <= '0;
      end
      stagger <= 1'b0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (wr && code == tcode(`CCA_C_TCTL, t))
          tctl[t] <= pwdata[5:0];
        if (wr && code == tcode(`CCA_C_TREL, t))
          rel[t] <= pwdata[TW-1:0]; // [R3]
        if (wr && code == tcode(`CCA_C_TCNT, t))
          cnt[t] <= pwdata[TW-1:0];
        else if (ovf[t])
          cnt[t] <= rel[t]; // [R18]
        else if (tick[t])
          cnt[t] <= cnt[t] + 1'b1; // [R3]
      end
      if (wr && code == `CCA_C_GLOB)
        stagger <= pwdata[0]; // [R2]
    end
  end

  // Compare acts only on the cycle after its time base moved, so a
  // slow time base that rests on one value fires once, not forever.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      match[i] = cfg[i].mode[2] && upd[cfg[i].tb] &&
                 cnt[cfg[i].tb] == val[i] && !done[i]; // [R11] [R17]
      case (cfg[i].mode)
        `CCA_M_RISE: cap[i] = ch_in[i] & ~pin_q[i]; // [R10]
        `CCA_M_FALL: cap[i] = ~ch_in[i] & pin_q[i]; // [R10]
        `CCA_M_BOTH: cap[i] = ch_in[i] ^ pin_q[i]; // [R10]
        default:     cap[i] = 1'b0;
      endcase
    end
    for (int i = 0; i < N; i++) begin
      if (i < N / 2)
        dhit[i] = cfg[i].dbl & (match[i] | match[(i + N / 2) % N]); // [R16]
      else
        dhit[i] = 1'b0;
    end
    for (int i = 0; i < N; i++) begin
      case (cfg[i].mode)
        `CCA_M_CMP0: ev[i] = match[i] | dhit[i]; // [R12]
        `CCA_M_CMP1: ev[i] = match[i] | dhit[i]; // [R13]
        `CCA_M_CMP2: ev[i] = match[i] & ~fired[i]; // [R14]
        `CCA_M_CMP3: ev[i] = match[i] & ~fired[i]; // [R15]
        default:     ev[i] = cap[i]; // [R9]
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        cfg[i] <= '0;
        val[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr && code == {`CCA_C_MODE, 4'(i)})
          cfg[i] <= pwdata[5:0]; // [R6]
        // A capture wins over a software write in the same cycle.
        if (cap[i])
          val[i] <= cnt[cfg[i].tb]; // [R8]
        else if (wr && code == {`CCA_C_VAL, 4'(i)})
          val[i] <= pwdata[TW-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out   <= 16'h0000;
      fired <= 16'h0000;
      done  <= 16'h0000;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr && code == {`CCA_C_MODE, 4'(i)}) begin
          fired[i] <= 1'b0;
          done[i]  <= 1'b0; // [R17]
        end else begin
          case (cfg[i].mode)
            `CCA_M_CMP0, `CCA_M_CMP1: begin
              if (ev[i]) begin
                if (cfg[i].mode == `CCA_M_CMP1 || dhit[i])
                  out[i] <= ~out[i]; // [R13] [R16]
                done[i] <= cfg[i].single; // [R17]
              end
            end
            `CCA_M_CMP2: begin
              if (ovf[cfg[i].tb])
                fired[i] <= 1'b0; // [R14]
              else if (ev[i]) begin
                fired[i] <= 1'b1; // [R14]
                done[i]  <= cfg[i].single; // [R17]
              end
            end
            `CCA_M_CMP3: begin
              if (ovf[cfg[i].tb]) begin
                out[i]   <= 1'b0; // [R15]
                fired[i] <= 1'b0;
              end else if (ev[i]) begin
                out[i]   <= 1'b1; // [R15]
                fired[i] <= 1'b1;
                done[i]  <= cfg[i].single; // [R17]
              end
            end
            default: begin
              fired[i] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= 16'h0000;
      en   <= 16'h0000;
    end else begin
      if (wr && code == `CCA_C_CLR)
        stat <= (stat & ~pwdata[15:0]) | ev; // [R9] [R12]
      else
        stat <= stat | ev; // [R9] [R12]
      if (wr && code == `CCA_C_EN)
        en <= pwdata[15:0];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (code == `CCA_C_TCTL)
      rd_val[5:0] = tctl[0];
    else if (code == `CCA_C_TCNT)
      rd_val[TW-1:0] = cnt[0];
    else if (code == `CCA_C_TREL)
      rd_val[TW-1:0] = rel[0];
    else if (code == tcode(`CCA_C_TCTL, 1))
      rd_val[5:0] = tctl[1];
    else if (code == tcode(`CCA_C_TCNT, 1))
      rd_val[TW-1:0] = cnt[1];
    else if (code == tcode(`CCA_C_TREL, 1))
      rd_val[TW-1:0] = rel[1];
    else if (code == `CCA_C_GLOB)
      rd_val[0] = stagger;
    else if (code == `CCA_C_STAT)
      rd_val[15:0] = stat;
    else if (code == `CCA_C_EN)
      rd_val[15:0] = en;
    else if (code == `CCA_C_PINS)
      rd_val = {ch_in, out};
    else if (code[6:4] == `CCA_C_MODE)
      rd_val[5:0] = cfg[code[3:0]];
    else if (code[6:4] == `CCA_C_VAL)
      rd_val[TW-1:0] = val[code[3:0]];
  end

  // Read data is caught in the setup cycle and held through access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_val;
  end
endmodule : cca_capcom16

// *** logic/cca_consts.svh ***
// Purpose: Shared constants of the capture/compare array.
// Assumes: APB byte addresses, 32-bit data, 12 address bits.
// Notes:   Timer codes advance by three for the second time base.
// How it works
// R1 - Sixteen channels, one clock cycle resolution.
// R2 - Staggered mode gives eight-cycle resolution.
// R3 - Two 16-bit time bases with reload registers.
// R4 - Time base clocked by prescaler or overflow timer.
// R5 - External count input can advance a time base.
// R6 - Each channel picks time base and function.
// R7 - One pin per channel, input or output.
// R8 - Capture latches time base on pin event.
// R9 - Each capture raises its channel interrupt.
// R10 - Capture edge: rising, falling or both.
// R11 - Compare channels match continuously against time base; the code compares only in the cycle after the time base moves.
// R12 - Mode 0: interrupt on every match.
// R13 - Mode 1: pin toggles on every match.
// R14 - Mode 2: one interrupt per timer period.
// R15 - Mode 3: set on match, clear on overflow.
// R16 - Double register: two matches toggle one pin.
// R17 - Single event option yields one edge only; in mode 3 the overflow still clears the pin afterwards.
// R18 - Time base reloads from reload register on overflow.
`ifndef CCA_CONSTS_SVH
`define CCA_CONSTS_SVH
`define CCA_NCH        16
`define CCA_TA_CTRL    12'h000
`define CCA_TA_CNT     12'h004
`define CCA_TA_REL     12'h008
`define CCA_TB_CTRL    12'h010
`define CCA_TB_CNT     12'h014
`define CCA_TB_REL     12'h018
`define CCA_GLOBAL     12'h020
`define CCA_IRQ_STAT   12'h024
`define CCA_IRQ_CLR    12'h028
`define CCA_IRQ_EN     12'h02C
`define CCA_PIN_STATE  12'h030
`define CCA_CH_MODE_HI 4'h1
`define CCA_CH_VAL_HI  4'h2
`define CCA_C_NONE     7'h00
`define CCA_C_TCTL     7'h01
`define CCA_C_TCNT     7'h02
`define CCA_C_TREL     7'h03
`define CCA_C_GLOB     7'h07
`define CCA_C_STAT     7'h08
`define CCA_C_CLR      7'h09
`define CCA_C_EN       7'h0A
`define CCA_C_PINS     7'h0B
`define CCA_C_MODE     3'b010
`define CCA_C_VAL      3'b100
`define CCA_SRC_PRE    2'h0
`define CCA_SRC_OVF    2'h1
`define CCA_M_OFF      3'h0
`define CCA_M_RISE     3'h1
`define CCA_M_FALL     3'h2
`define CCA_M_BOTH     3'h3
`define CCA_M_CMP0     3'h4
`define CCA_M_CMP1     3'h5
`define CCA_M_CMP2     3'h6
`define CCA_M_CMP3     3'h7
`define CCA_STAGGER    3'h7
`endif

// *** logic/cca_pkg.sv ***
// Purpose: Types of the capture/compare array.
// Assumes: Field layouts match the register bit order.
// Notes:   Struct bit order is the register bit order.
package cca_pkg;
  typedef struct packed {
    logic [2:0] ps;
    logic [1:0] src;
    logic       run;
  } cca_tctl_s;
  typedef struct packed {
    logic       dbl;
    logic       single;
    logic       tb;
    logic [2:0] mode;
  } cca_chcfg_s;
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe_n;
  } cca_pins_s;
endpackage : cca_pkg

// *** verif/cca_monitor.sv ***
// Purpose: Port checker for the capture/compare array.
// Assumes: Zero-wait APB slave; shadows copy mode and enable writes.
// Notes:   Shadows update on the same edge as the registers they copy.
`timescale 1ns/1ps
`include "cca_consts.svh"
module cca_monitor (
  input logic               pclk,
  input logic               presetn,
  input logic               psel,
  input logic               penable,
  input logic               pwrite,
  input logic [11:0]        paddr,
  input logic [31:0]        pwdata,
  input logic [31:0]        prdata,
  input logic               pready,
  input logic               pslverr,
  input logic [15:0]        ch_in,
  input cca_pkg::cca_pins_s ch_pins,
  input logic               ext_ovf_pulse,
  input logic               ext_count_in,
  input logic               irq
);
  import cca_pkg::*;
  cca_chcfg_s  cfg [16];
  logic [15:0] en;
  logic [15:0] exp_oe_n;
  logic        wr;
  logic        mapped;
  assign mapped = paddr[1:0] == 2'h0 && (paddr[11:6] == 6'h04 ||
    paddr[11:6] == 6'h08 || (paddr[11:6] == 6'h00 && paddr[5:2] <= 4'hC
    && (paddr[5] || paddr[3:2] != 2'h3)));
  assign wr = psel && penable && pwrite && mapped;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{default: '0};
      en  <= 16'h0000;
    end else if (wr) begin
      if (paddr[11:6] == 6'h04) cfg[paddr[5:2]] <= pwdata[5:0];
      if (paddr == `CCA_IRQ_EN) en <= pwdata[15:0];
    end
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      exp_oe_n[i] = !(cfg[i].mode inside {`CCA_M_CMP1, `CCA_M_CMP3} ||
        (cfg[i].mode == `CCA_M_CMP0 && cfg[i].dbl));
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  property p_ready; psel && penable |-> pready; endproperty
  property p_err; psel && penable |-> pslverr == !mapped; endproperty
  property p_rd_zero;
    s_rd_setup ##0 (paddr == `CCA_IRQ_CLR || !mapped) |=> prdata == 0;
  endproperty
  property p_pins_rd;
    s_rd_setup ##0 paddr == `CCA_PIN_STATE
      |=> prdata == {$past(ch_in), $past(ch_pins.out)};
  endproperty
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  property p_oe; ch_pins.oe_n == exp_oe_n; endproperty
  property p_cap_irq;
    $rose(ch_in[0]) && en[0] &&
      cfg[0].mode inside {`CCA_M_RISE, `CCA_M_BOTH} |=> irq;
  endproperty
  property p_en_off;
    wr && paddr == `CCA_IRQ_EN && pwdata[15:0] == 16'h0000 |=> !irq;
  endproperty
  property p_irq_cause; irq |-> en != 16'h0000; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err: assert property (p_err) else $error("bad pslverr");
  a_rd_zero: assert property (p_rd_zero) else $error("not zero");
  a_pins_rd: assert property (p_pins_rd) else $error("pin read");
  a_hold: assert property (p_hold) else $error("prdata moved");
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_cap_irq: assert property (p_cap_irq) else $error("no irq");
  a_en_off: assert property (p_en_off) else $error("irq masked");
  a_irq_cause: assert property (p_irq_cause) else $error("irq");
endmodule : cca_monitor
bind cca_capcom16 cca_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ch_in(ch_in), .ch_pins(ch_pins), .ext_ovf_pulse(ext_ovf_pulse),
  .ext_count_in(ext_count_in), .irq(irq));

// *** verif/cca_pin_model.sv ***
// Purpose: Far-side pin model driving channel pins and the count input.
// Assumes: A pin the array drives reads back its own level.
// Notes:   Count input lags one clock, as a pin synchroniser would.
`timescale 1ns/1ps
module cca_pin_model (
  input  logic               pclk,
  input  cca_pkg::cca_pins_s pins,
  input  logic [15:0]        drv,
  input  logic               cnt_go,
  output logic [15:0]        ch_in,
  output logic               ext_count_in = 1'b0
);
  import cca_pkg::*;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      ch_in[i] = pins.oe_n[i] ? drv[i] : pins.out[i];
    end
  end
  always @(posedge pclk) begin
    ext_count_in <= cnt_go;
  end
endmodule : cca_pin_model

// *** verif/capture_compare_array_16ch_tb_top.sv ***
// Purpose: Self-checking bench for the capture/compare array.
// Assumes: Zero-wait slave, yet every bus wait is bounded anyway.
// Notes:   The compare test steps its timer by the count input, so every value is exact.
`timescale 1ns/1ps
`include "cca_consts.svh"
module capture_compare_array_16ch_tb_top;
  import cca_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, ovf = 1'b0, cnt_go = 1'b0, irq, pready;
  logic        pslverr, ext_count_in, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, dlt;
  logic [15:0] drv = 16'h0000, ch_in;
  cca_pins_s   pins;
  int          bad_count = 0, checks_done = 0;
  int          mt [6] = '{5, 7, 4, 6, 'h25, 'h15};
  always #5 pclk = ~pclk;
  cca_capcom16 dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_in(ch_in),
    .ch_pins(pins), .ext_ovf_pulse(ovf), .ext_count_in(ext_count_in),
    .irq(irq));
  cca_pin_model far (.pclk(pclk), .pins(pins), .drv(drv), .cnt_go(cnt_go),
    .ch_in(ch_in), .ext_count_in(ext_count_in));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        give_verdict();
      end
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // A fixed settle follows each count, since pins move three edges after cnt_go rises.
  task automatic step;
    @(posedge pclk);
    cnt_go <= 1'b1;
    repeat (2) @(posedge pclk);
    cnt_go <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask : step
  task automatic t_capture;
    wr(`CCA_TA_CNT, 32'h0ABC);
    wr(`CCA_TB_CNT, 32'h1234);
    wr(12'h100, 32'h9);
    wr(12'h104, 32'h2);
    wr(12'h124, 32'hB);
    wr(`CCA_IRQ_EN, 32'h1);
    @(posedge pclk);
    drv <= 16'h0203;
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(`CCA_TB_CNT, 32'h5678);
    @(posedge pclk);
    drv <= 16'h0000;
    rd(12'h200);
    chk("val0", q, 32'h1234);
    rd(12'h204);
    chk("val1", q, 32'h0ABC);
    rd(12'h224);
    chk("val9", q, 32'h5678);
    wr(`CCA_IRQ_STAT, 32'h0);
    wr(`CCA_IRQ_CLR, 32'h1);
    rd(`CCA_IRQ_STAT);
    chk("stat", q, 32'h0202);
    chk("irq clr", {31'h0, irq}, 32'h0);
    rd(12'h034);
    chk("unmapped", {e, q[30:0]}, 32'h80000000);
    wr(`CCA_IRQ_EN, 32'h0);
    wr(`CCA_IRQ_CLR, 32'hFFFF);
  endtask : t_capture
  task automatic t_ovf_src;
    wr(`CCA_TB_CTRL, 32'h3);
    wr(`CCA_TB_CNT, 32'h0041);
    @(posedge pclk);
    ovf <= 1'b1;
    @(posedge pclk);
    ovf <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(`CCA_TB_CNT);
    chk("tb ovf", q, 32'h0042);
    wr(`CCA_TB_CTRL, 32'h0);
  endtask : t_ovf_src
  task automatic t_compare;
    wr(`CCA_TA_CTRL, 32'h5);
    wr(`CCA_TA_REL, 32'h0100);
    wr(`CCA_TA_CNT, 32'hFFFE);
    for (int i = 0; i < 6; i++) begin
      wr(12'h108 + 12'(4 * i), 32'(mt[i]));
      wr(12'h208 + 12'(4 * i), 32'hFFFF);
    end
    wr(12'h138, 32'h4);
    wr(12'h238, 32'h0101);
    step();
    rd(`CCA_PIN_STATE);
    chk("pins a", {26'h0, q[7:2]}, 32'h33);
    rd(`CCA_IRQ_STAT);
    chk("stat a", q, 32'h00FC);
    wr(`CCA_IRQ_CLR, 32'hFFFF);
    wr(`CCA_TA_CNT, 32'hFFFE);
    step();
    rd(`CCA_IRQ_STAT);
    chk("stat b", q, 32'h0054);
    rd(`CCA_PIN_STATE);
    chk("pins b", {26'h0, q[7:2]}, 32'h22);
    step();
    rd(`CCA_TA_CNT);
    chk("reload", q, 32'h0100);
    rd(`CCA_PIN_STATE);
    chk("pins c", {26'h0, q[7:2]}, 32'h20);
    step();
    rd(`CCA_PIN_STATE);
    chk("pins d", {26'h0, q[7:2]}, 32'h30);
    wr(`CCA_TA_CTRL, 32'h0);
  endtask : t_compare
  // Two read setups 64 edges apart, so the tick count is phase-free.
  task automatic span(input logic [31:0] ctl);
    logic [31:0] q0;
    wr(`CCA_TB_CTRL, ctl);
    rd(`CCA_TB_CNT);
    q0 = q;
    repeat (61) @(posedge pclk);
    rd(`CCA_TB_CNT);
    dlt = q - q0;
  endtask : span
  task automatic t_presc;
    span(32'h11);
    chk("presc", dlt, 32'h10);
    span(32'h01);
    chk("full rate", dlt, 32'h40);
    wr(`CCA_GLOBAL, 32'h1);
    span(32'h01);
    chk("stagger", dlt, 32'h08);
    wr(`CCA_TB_CTRL, 32'h0);
    wr(`CCA_GLOBAL, 32'h0);
  endtask : t_presc
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CCA_IRQ_STAT);
    chk("stat reset", q, 32'h0);
    t_capture();
    t_ovf_src();
    t_compare();
    t_presc();
    give_verdict();
  end
endmodule : capture_compare_array_16ch_tb_top
